// ==== inc/standard_timer_pkg.sv ====
package standard_timer_pkg;

  // =======================================================
  // bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int COUNT_W = 16;

  // =======================================================
  // register byte offsets, one aligned word each
  localparam logic [4:0] OFS_RUN_CONTROL = 5'h00;
  localparam logic [4:0] OFS_MODE_PIN = 5'h04;
  localparam logic [4:0] OFS_COUNT_LO = 5'h08;
  localparam logic [4:0] OFS_COUNT_HI = 5'h0C;
  localparam logic [4:0] OFS_CMPA_LO = 5'h10;
  localparam logic [4:0] OFS_CMPA_HI = 5'h14;
  localparam logic [4:0] OFS_CMPP = 5'h18;
  localparam logic [4:0] OFS_FLAGS = 5'h1C;

  // =======================================================
  // field positions
  localparam int RUN_BIT = 3;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 4;
  localparam int OC_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int DPX_BIT = 1;
  localparam int CCLR_BIT = 0;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;

  // =======================================================
  // reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [16:0] PERIOD_FULL = 17'h1_0000;

  // =======================================================
  // operating modes and pin functions
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } timer_mode_t;

  localparam logic [1:0] FN_CMP_NONE = 2'h0;
  localparam logic [1:0] FN_CMP_LOW = 2'h1;
  localparam logic [1:0] FN_CMP_HIGH = 2'h2;
  localparam logic [1:0] FN_CMP_TOGGLE = 2'h3;
  localparam logic [1:0] FN_PWM_INACTIVE = 2'h0;
  localparam logic [1:0] FN_PWM_ACTIVE = 2'h1;
  localparam logic [1:0] FN_PWM_WAVE = 2'h2;
  localparam logic [1:0] FN_PWM_PULSE = 2'h3;
  localparam logic [1:0] FN_CAP_RISE = 2'h0;
  localparam logic [1:0] FN_CAP_FALL = 2'h1;
  localparam logic [1:0] FN_CAP_BOTH = 2'h2;
  localparam logic [1:0] FN_CAP_OFF = 2'h3;

endpackage

// ==== logic/stm_compare_unit.sv ====
`timescale 1ns/10ps
module stm_compare_unit #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] i_count,
  input wire logic [WIDTH-1:0] i_value,
  output logic o_match
);

  // pure equality, the caller qualifies it with the tick
  assign o_match = (i_count == i_value);

endmodule

// ==== logic/standard_timer.sv ====
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
// Notes on behaviour
// - run rising clears counter; run falling keeps the residual count
// - run low stops counting, timer sits powered down
// - run rising restores initial pin level in compare mode; pulse mode drives the active level
// - low three bits of run control register read as zero
// - two-bit mode field picks compare, capture, PWM/pulse or timer
// - compare mode: A match leaves, lowers, raises or toggles pin
// - PWM mode: force inactive, force active, PWM wave, single pulse
// - capture mode: rising, falling, both edges or disabled
// - output control bit is initial level or active level
// - polarity bit inverts pin; both bits idle in timer mode
// - swap bit exchanges period and duty roles of P and A
// - clear select: A match, or P match/overflow
// - overflow clear only with compare P zero, wraps at maximum
// - clear select ignored in PWM, pulse and capture modes
// - counter readable as two read-only bytes, reset zero
// - compare A is 16-bit read/write, full-width compare
// - compare P checks the full count against {P,00} minus one, 256-tick steps
// - P period 65536 ticks for zero, else value times 256
// - low bytes pass a shared buffer, latched by high byte access
// - compare mode with A clear never sets the P flag
module standard_timer #(
  parameter int COUNT_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [standard_timer_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [standard_timer_pkg::DATA_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [standard_timer_pkg::DATA_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_timer_tick,
  input wire logic i_capture_pin,
  output logic o_timer_output_pin,
  output logic o_timer_output_oe,
  output logic o_compare_a_flag,
  output logic o_compare_p_flag
);

  // =======================================================
  // state
  logic ack_reg;
  logic [standard_timer_pkg::DATA_W-1:0] rdat_reg;
  logic run_reg;
  logic [7:0] mode_pin_reg;
  logic [7:0] cmp_p_reg;
  logic [COUNT_W-1:0] cmp_a_reg;
  logic [COUNT_W-1:0] count_reg;
  logic [7:0] buf_reg;
  logic level_reg;
  logic flag_a_reg;
  logic flag_p_reg;
  logic pin_reg;
  logic oe_reg;
  logic cap_s1_reg;
  logic cap_s2_reg;
  logic cap_s3_reg;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // =======================================================
  // bus decode
  wire req = i_wb_cyc & i_wb_stb & ~ack_reg;
  wire wr = req & i_wb_we & i_wb_sel[0];
  wire rd = req & ~i_wb_we;
  wire hit_run = (i_wb_adr == standard_timer_pkg::OFS_RUN_CONTROL);
  wire hit_mode = (i_wb_adr == standard_timer_pkg::OFS_MODE_PIN);
  wire hit_cnt_lo = (i_wb_adr == standard_timer_pkg::OFS_COUNT_LO);
  wire hit_cnt_hi = (i_wb_adr == standard_timer_pkg::OFS_COUNT_HI);
  wire hit_a_lo = (i_wb_adr == standard_timer_pkg::OFS_CMPA_LO);
  wire hit_a_hi = (i_wb_adr == standard_timer_pkg::OFS_CMPA_HI);
  wire hit_p = (i_wb_adr == standard_timer_pkg::OFS_CMPP);
  wire hit_flags = (i_wb_adr == standard_timer_pkg::OFS_FLAGS);
  wire [7:0] wbyte = i_wb_dat[7:0];

  // =======================================================
  // control fields
  // mode decode
  wire [1:0] mode = mode_pin_reg[standard_timer_pkg::MODE_HI:standard_timer_pkg::MODE_LO];
  wire [1:0] func = mode_pin_reg[standard_timer_pkg::FUNC_HI:standard_timer_pkg::FUNC_LO];
  wire oc = mode_pin_reg[standard_timer_pkg::OC_BIT];
  wire pol = mode_pin_reg[standard_timer_pkg::POL_BIT];
  wire dpx = mode_pin_reg[standard_timer_pkg::DPX_BIT];
  wire cclr = mode_pin_reg[standard_timer_pkg::CCLR_BIT];
  wire in_cmp = (mode == standard_timer_pkg::MODE_COMPARE);
  wire in_cap = (mode == standard_timer_pkg::MODE_CAPTURE);
  wire in_pwm = (mode == standard_timer_pkg::MODE_PWM);
  wire in_tmr = (mode == standard_timer_pkg::MODE_TIMER);
  wire cmp_like = in_cmp | in_tmr;
  wire sp_mode = in_pwm & (func == standard_timer_pkg::FN_PWM_PULSE);

  // =======================================================
  // comparators
  logic a_match;
  logic p_match;
  // P match one tick before the counter reaches {P,00}; zero wraps at FFFF
  wire [COUNT_W-1:0] p_target = COUNT_W'({cmp_p_reg, 8'h00} - 16'h0001);

  stm_compare_unit #(.WIDTH(COUNT_W)) u_cmp_a (
    .i_count(count_reg),
    .i_value(cmp_a_reg),
    .o_match(a_match)
  );

  // period of P*256 ticks, 65536 for zero
  stm_compare_unit #(.WIDTH(COUNT_W)) u_cmp_p (
    .i_count(count_reg),
    .i_value(p_target),
    .o_match(p_match)
  );

  // =======================================================
  // counter events
  // ticks are ignored while stopped
  wire count_adv = i_timer_tick & run_reg;
  wire a_nonzero = (cmp_a_reg != 16'h0000);
  wire a_evt = count_adv & a_match & a_nonzero;
  // no P flag in compare/timer mode with A clear
  wire p_evt = count_adv & p_match & ~(cmp_like & cclr);
  // zero compare A never clears, so the count overflows instead
  wire a_hit = a_match & a_nonzero;
  wire clear_hit = in_pwm ? (dpx ? a_hit : p_match) :
                   in_cap ? p_match :
                   (cclr ? a_hit : p_match);
  // single pulse ends on compare A
  wire sp_end = sp_mode & a_evt;

  // =======================================================
  // run bit
  wire run_next = (wr & hit_run) ? wbyte[standard_timer_pkg::RUN_BIT] :
                  (sp_end ? 1'b0 : run_reg);
  // edge seen as it is written
  wire run_rise = run_next & ~run_reg;

  // clear on rise; a match tick loads zero, not the increment
  wire [COUNT_W-1:0] count_next = run_rise ? standard_timer_pkg::COUNT_RESET :
                                  !count_adv ? count_reg :
                                  clear_hit ? standard_timer_pkg::COUNT_RESET :
                                  COUNT_W'(count_reg + 16'h0001);
  // so the counter spans 0 to target, one tick per state

  // =======================================================
  // capture input
  // edge select on the synchronised pin
  wire cap_rise = cap_s2_reg & ~cap_s3_reg;
  wire cap_fall = ~cap_s2_reg & cap_s3_reg;
  wire cap_edge = (func == standard_timer_pkg::FN_CAP_RISE) ? cap_rise :
                  (func == standard_timer_pkg::FN_CAP_FALL) ? cap_fall :
                  (func == standard_timer_pkg::FN_CAP_BOTH) ? (cap_rise | cap_fall) :
                  1'b0;
  wire cap_evt = in_cap & run_reg & cap_edge;

  // =======================================================
  // registers behind the byte buffer
  // high byte access moves the low byte through the buffer
  wire [7:0] buf_next = (wr & hit_a_lo) ? wbyte :
                        (rd & hit_cnt_hi) ? count_reg[7:0] :
                        (rd & hit_a_hi) ? cmp_a_reg[7:0] :
                        buf_reg;
  wire [COUNT_W-1:0] cmp_a_next = (wr & hit_a_hi) ? {wbyte, buf_reg} :
                                  cap_evt ? count_reg : cmp_a_reg;
  wire [7:0] mode_pin_next = (wr & hit_mode) ? wbyte : mode_pin_reg;
  wire [7:0] cmp_p_next = (wr & hit_p) ? wbyte : cmp_p_reg;

  // =======================================================
  // flags, set wins over the write-one clear
  wire clr_a = wr & hit_flags & wbyte[standard_timer_pkg::FLAG_A_BIT];
  wire clr_p = wr & hit_flags & wbyte[standard_timer_pkg::FLAG_P_BIT];
  // a capture edge also raises the A flag
  wire set_a = a_evt | cap_evt;
  wire flag_a_next = set_a | (flag_a_reg & ~clr_a);
  wire flag_p_next = p_evt | (flag_p_reg & ~clr_p);

  // =======================================================
  // output pin
  // compare A match action
  wire cmp_level = (func == standard_timer_pkg::FN_CMP_LOW) ? 1'b0 :
                   (func == standard_timer_pkg::FN_CMP_HIGH) ? 1'b1 :
                   (func == standard_timer_pkg::FN_CMP_TOGGLE) ? ~level_reg :
                   level_reg;
  // initial level restored on run rise
  wire level_next = (run_rise & in_cmp) ? oc :
                    (in_cmp & a_evt) ? cmp_level : level_reg;
  // duty source, zero P meaning 65536
  wire [16:0] p_span = (cmp_p_reg == 8'h00) ? standard_timer_pkg::PERIOD_FULL :
                       {1'b0, cmp_p_reg, 8'h00};
  wire [16:0] duty = dpx ? p_span : {1'b0, cmp_a_reg};
  // duty at or past the period gives 100 percent
  wire duty_on = ({1'b0, count_reg} < duty);
  // PWM functions with oc as active level
  wire pwm_level = (func == standard_timer_pkg::FN_PWM_INACTIVE) ? ~oc :
                   (func == standard_timer_pkg::FN_PWM_ACTIVE) ? oc :
                   (func == standard_timer_pkg::FN_PWM_WAVE) ? ((run_reg & duty_on) ? oc : ~oc) :
                   (run_next ? oc : ~oc);
  wire raw_level = in_cmp ? level_next : (in_pwm ? pwm_level : 1'b0);
  // polarity has no effect in timer mode
  wire pin_next = (in_cmp | in_pwm) ? (raw_level ^ pol) : 1'b0;
  wire oe_next = in_cmp | in_pwm;

  // =======================================================
  // read mux; reserved and pause/clock bits read zero
  wire [7:0] rbyte = hit_run ? {4'h0, run_reg, 3'h0} :
                     hit_mode ? mode_pin_reg :
                     (hit_cnt_lo | hit_a_lo) ? buf_reg :
                     hit_cnt_hi ? count_reg[15:8] :
                     hit_a_hi ? cmp_a_reg[15:8] :
                     hit_p ? cmp_p_reg :
                     hit_flags ? {6'h00, flag_p_reg, flag_a_reg} :
                     standard_timer_pkg::BYTE_RESET;
  wire [standard_timer_pkg::DATA_W-1:0] rdat_next = {24'h00_0000, rbyte};

  // =======================================================
  // flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg <= 1'b0;
      rdat_reg <= standard_timer_pkg::DATA_ZERO;
    end else begin
      ack_reg <= req;
      rdat_reg <= rd ? rdat_next : standard_timer_pkg::DATA_ZERO;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_reg <= 1'b0;
      mode_pin_reg <= standard_timer_pkg::BYTE_RESET;
      cmp_p_reg <= standard_timer_pkg::BYTE_RESET;
      cmp_a_reg <= standard_timer_pkg::COUNT_RESET;
      buf_reg <= standard_timer_pkg::BYTE_RESET;
    end else begin
      run_reg <= run_next;
      mode_pin_reg <= mode_pin_next;
      cmp_p_reg <= cmp_p_next;
      cmp_a_reg <= cmp_a_next;
      buf_reg <= buf_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_reg <= standard_timer_pkg::COUNT_RESET;
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      flag_a_reg <= flag_a_next;
      flag_p_reg <= flag_p_next;
    end
  end

  // capture pin passes two flops before the edge detector
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cap_s1_reg <= 1'b0;
      cap_s2_reg <= 1'b0;
      cap_s3_reg <= 1'b0;
    end else begin
      cap_s1_reg <= i_capture_pin;
      cap_s2_reg <= cap_s1_reg;
      cap_s3_reg <= cap_s2_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level_reg <= 1'b0;
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;
  assign o_timer_output_pin = pin_reg;
  assign o_timer_output_oe = oe_reg;
  assign o_compare_a_flag = flag_a_reg;
  assign o_compare_p_flag = flag_p_reg;

  // =======================================================
  // checks
  AST_RUN_RISE_CLEARS: assert property (
    run_rise |=> (count_reg == 16'h0000)
  ) else $error("counter not cleared on run rise");

  AST_STOPPED_HOLDS: assert property (
    (!run_reg && !run_rise) |=> $stable(count_reg)
  ) else $error("counter moved while stopped");

  AST_RESERVED_ZERO: assert property (
    (rd && hit_run) |=> o_wb_ack && (o_wb_dat[2:0] == 3'h0)
  ) else $error("reserved run control bits not zero");

  AST_CLEAR_NEXT_TICK: assert property (
    (count_adv && clear_hit && !run_rise) |=> (count_reg == 16'h0000)
  ) else $error("match clear not applied on next tick");

  AST_A_CLEAR_SELECT: assert property (
    (count_adv && cmp_like && cclr && a_match && a_nonzero && !run_rise) |=> (count_reg == 16'h0000)
  ) else $error("compare A match did not arm the clear");

  AST_NO_P_FLAG: assert property (
    (cmp_like && cclr && !flag_p_reg) |=> !flag_p_reg
  ) else $error("P flag raised with A clear selected");

  AST_TOGGLE_PIN: assert property (
    (in_cmp && func == standard_timer_pkg::FN_CMP_TOGGLE && a_evt && !run_rise
      && !(wr && hit_mode)) |=> (level_reg != $past(level_reg)) ##1 (o_timer_output_pin
      == (level_reg ^ pol))
  ) else $error("toggle action missing on compare A");

  AST_BUFFER_LATCH: assert property (
    (wr && hit_a_hi) |=> (cmp_a_reg[7:0] == $past(buf_reg)) && (cmp_a_reg[15:8]
      == $past(i_wb_dat[7:0]))
  ) else $error("compare A low byte not latched from buffer");

  AST_ACK_PULSE: assert property (
    req |=> o_wb_ack ##1 !o_wb_ack
  ) else $error("ack not a single cycle pulse");

  AST_TIMER_MODE_IDLE: assert property (
    in_tmr |=> !o_timer_output_oe && !o_timer_output_pin
  ) else $error("pin driven in timer mode");

endmodule

// ==== tb/pin_partner.sv ====
`timescale 1ns/10ps
// ==========================================
// far side: capture source and pin monitor
module pin_partner (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  input wire logic i_oe,
  input wire logic i_cap_level,
  output logic o_capture_pin,
  output logic [15:0] o_high_cnt
);
  // edge source, active count
  // pin is only counted while driven; a released pin tells nothing
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_capture_pin <= 1'b0;
      o_high_cnt <= 16'h0000;
    end else begin
      o_capture_pin <= i_cap_level;
      if (i_oe && i_pin) begin
        o_high_cnt <= o_high_cnt + 16'h0001;
      end
    end
  end
endmodule

// ==== tb/standard_timer_test.sv ====
`timescale 1ns/10ps
module standard_timer_test;
  // ==========================================
  // bench signals
  logic clk, rstn, cyc, stb, we, tick, cap_level, ack, pin, oe, fa, fp, cap_pin;
  logic [4:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [15:0] high_cnt, h0;
  logic [7:0] q;
  int n_mismatch, num_checks;

  standard_timer standard_timer_inst (
    .i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_timer_tick(tick), .i_capture_pin(cap_pin), .o_timer_output_pin(pin),
    .o_timer_output_oe(oe), .o_compare_a_flag(fa), .o_compare_p_flag(fp)
  );
  pin_partner pin_partner_inst (
    .i_clk(clk), .i_rstn(rstn), .i_pin(pin), .i_oe(oe), .i_cap_level(cap_level),
    .o_capture_pin(cap_pin), .o_high_cnt(high_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED time %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask
  task automatic run(input logic on);
    wb(1'b1, standard_timer_pkg::OFS_RUN_CONTROL, {4'h0, on, 3'h0});
  endtask
  task automatic cfg(input logic [7:0] m);
    wb(1'b1, standard_timer_pkg::OFS_RUN_CONTROL, 8'h00);
    wb(1'b1, standard_timer_pkg::OFS_FLAGS, 8'h03);
    wb(1'b1, standard_timer_pkg::OFS_MODE_PIN, m);
  endtask
  task automatic seta(input logic [15:0] v);
    wb(1'b1, standard_timer_pkg::OFS_CMPA_LO, v[7:0]);
    wb(1'b1, standard_timer_pkg::OFS_CMPA_HI, v[15:8]);
  endtask
  task automatic cnt(input logic [15:0] e);
    rd(standard_timer_pkg::OFS_COUNT_HI, e[15:8]);
    rd(standard_timer_pkg::OFS_COUNT_LO, e[7:0]);
  endtask
  task automatic ticks(input int n);
    tick <= 1'b1;
    repeat (n) @(posedge clk);
    tick <= 1'b0;
  endtask
  // pin register lags a cycle, so look two falling edges on
  task automatic pins(input logic [3:0] e, input logic [3:0] m);
    repeat (2) @(negedge clk);
    chk({12'h000, m & {oe, pin, fp, fa}}, {12'h000, m & e});
    @(posedge clk);
  endtask
  task automatic duty(input logic [15:0] e);
    tick <= 1'b1;
    repeat (300) @(posedge clk);
    h0 = high_cnt;
    repeat (256) @(posedge clk);
    chk(high_cnt - h0, e);
    tick <= 1'b0;
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), 8'h00);
    end
    pins(4'h0, 4'h7);
    wb(1'b1, standard_timer_pkg::OFS_RUN_CONTROL, 8'hFF);
    rd(standard_timer_pkg::OFS_RUN_CONTROL, 8'h08);
    wb(1'b1, 5'h01, 8'hFF);
    rd(5'h01, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_count();
    cfg(8'hC0);
    run(1'b1);
    ticks(5);
    cnt(16'h0005);
    pins(4'h0, 4'h8);
    run(1'b0);
    ticks(3);
    cnt(16'h0005);
    run(1'b1);
    cnt(16'h0000);
    seta(16'h1234);
    rd(standard_timer_pkg::OFS_CMPA_HI, 8'h12);
    rd(standard_timer_pkg::OFS_CMPA_LO, 8'h34);
    $display("t_count done");
  endtask
  task automatic t_compare();
    logic [1:0] fn [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    logic [3:0] oc = 4'b1001;
    logic [3:0] ex = 4'b1110;
    seta(16'h0003);
    for (int i = 0; i < 4; i++) begin
      cfg({2'b00, fn[i], oc[i], 3'b001});
      run(1'b1);
      pins({1'b1, oc[i], 2'b00}, 4'hF);
      ticks(5);
      pins({1'b1, ex[i], 2'b01}, 4'hF);
    end
    cfg(8'h1D);
    run(1'b1);
    ticks(5);
    pins(4'b1101, 4'hF);
    run(1'b0);
    run(1'b1);
    pins(4'b1001, 4'hF);
    $display("t_compare done");
  endtask
  task automatic t_clear();
    seta(16'h0000);
    wb(1'b1, standard_timer_pkg::OFS_CMPP, 8'h01);
    cfg(8'h00);
    run(1'b1);
    ticks(261);
    cnt(16'h0005);
    pins(4'b1010, 4'hF);
    wb(1'b1, standard_timer_pkg::OFS_CMPP, 8'h00);
    cfg(8'h00);
    run(1'b1);
    ticks(65538);
    cnt(16'h0002);
    seta(16'h0003);
    wb(1'b1, standard_timer_pkg::OFS_CMPP, 8'h01);
    cfg(8'h01);
    run(1'b1);
    ticks(300);
    cnt(16'h0000);
    pins(4'b1001, 4'hF);
    $display("t_clear done");
  endtask
  task automatic t_pwm();
    seta(16'h0040);
    wb(1'b1, standard_timer_pkg::OFS_CMPP, 8'h01);
    cfg(8'hA9);
    run(1'b1);
    duty(16'd64);
    cfg(8'hAB);
    run(1'b1);
    duty(16'd256);
    cfg(8'h89);
    run(1'b1);
    ticks(10);
    pins(4'b1000, 4'hC);
    cfg(8'h99);
    run(1'b1);
    ticks(10);
    pins(4'b1100, 4'hC);
    cfg(8'h9D);
    run(1'b1);
    ticks(10);
    pins(4'b1000, 4'hC);
    cfg(8'hB8);
    run(1'b1);
    pins(4'b1100, 4'hC);
    ticks(100);
    pins(4'b1000, 4'hC);
    rd(standard_timer_pkg::OFS_RUN_CONTROL, 8'h00);
    $display("t_pwm done");
  endtask
  task automatic t_capture();
    for (int i = 0; i < 4; i++) begin
      cfg({2'b01, 2'(i), 4'h0});
      run(1'b1);
      cap_level <= 1'b1;
      repeat (6) @(posedge clk);
      pins({3'b000, i == 0 || i == 2}, 4'h9);
      wb(1'b1, standard_timer_pkg::OFS_FLAGS, 8'h03);
      cap_level <= 1'b0;
      repeat (6) @(posedge clk);
      pins({3'b000, i == 1 || i == 2}, 4'h9);
    end
    $display("t_capture done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    {cyc, stb, we, tick, cap_level} = 5'b00000;
    adr = 5'h00;
    wdat = 32'h00000000;
    sel = 4'h0;
    rstn = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_count();
    t_compare();
    t_clear();
    t_pwm();
    t_capture();
    end_sim();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule
